//--- include/lpsc_pkg.sv
// constants for the ldo pair state control register bank
`default_nettype none
package lpsc_pkg;
    localparam logic [7:0] LDO_ONE_CONTROL_ADDR = 8'h3F;
    localparam logic [7:0] LDO_TWO_CONTROL_ADDR = 8'h40;
    localparam logic [7:0] LDO_ONE_CONTROL_RESET = 8'h24;
    localparam logic [7:0] LDO_TWO_CONTROL_RESET = 8'h3C;
    localparam int STATE_LSB = 0;
    localparam int STATE_MSB = 2;
    localparam int EXIT_LSB = 3;
    localparam int EXIT_MSB = 5;
    localparam logic [7:0] WRITABLE_MASK = 8'h3F;
    localparam logic [2:0] CODE_OFF = 3'h4;
    localparam logic [2:0] CODE_LOW_POWER = 3'h5;
    localparam logic [2:0] CODE_ACTIVE_A = 3'h6;
    localparam logic [2:0] CODE_ACTIVE_B = 3'h7;
    // decoded operating mode of one regulator
    typedef enum logic [1:0] {
        LPSC_MODE_RESERVED = 2'b00,
        LPSC_MODE_OFF = 2'b01,
        LPSC_MODE_LOW_POWER = 2'b10,
        LPSC_MODE_ACTIVE = 2'b11
    } lpsc_mode_t;
endpackage
`default_nettype wire

//--- rtl/lpsc_top.sv
// register bank and state decode for the two ldos on the shared input pin
//
// Summary of operation
// - state field decodes off, low power, active
// - standby exit copies valid exit field to state
// - ldo one control at 3F, reset 24
// - ldo two control at 40, reset 3C
// - the two regulators are controlled independently
// - discharge enabled while state selects off
// - per regulator over-current and under-voltage flags
// - ldo one low power only when programmed
`timescale 1ns/1ps
`default_nettype none
module lpsc_top
    import lpsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wr_en_i,                // one-cycle register write strobe
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wr_data_i,
    output logic [7:0] rd_data_o,            // registered read of addr_i
    input wire logic standby_exit_pin_i,     // asynchronous pin
    input wire logic [1:0] over_current_i,   // analog comparators, async
    input wire logic [1:0] under_voltage_i,  // analog comparators, async
    output logic [1:0] ldo_one_mode_o,
    output logic [1:0] ldo_two_mode_o,
    output logic [1:0] discharge_o,          // bit 0 ldo one, bit 1 ldo two
    output logic [1:0] over_current_o,
    output logic [1:0] under_voltage_o
);
    ////////////////////////////////////////////////////////////////////////
    // state record
    typedef struct packed {
        logic [7:0] ctl_one;     // ldo_one_control
        logic [7:0] ctl_two;     // ldo_two_control
        logic [7:0] rd_data;
        logic [2:0] exit_sync;   // two sync stages plus edge history
        logic [1:0] oc_s1;
        logic [1:0] oc_s2;
        logic [1:0] uv_s1;
        logic [1:0] uv_s2;
        logic [1:0] oc_flag;
        logic [1:0] uv_flag;
        lpsc_mode_t mode_one;
        lpsc_mode_t mode_two;
        logic [1:0] discharge;
    } lpsc_state_t;

    lpsc_state_t state_reg;
    lpsc_state_t state_next;

    // decode of a 3-bit state field into a mode
    function automatic lpsc_mode_t decode_mode(input logic [2:0] code);
        case (code)
            CODE_OFF: decode_mode = LPSC_MODE_OFF;
            CODE_LOW_POWER: decode_mode = LPSC_MODE_LOW_POWER;
            CODE_ACTIVE_A: decode_mode = LPSC_MODE_ACTIVE;
            CODE_ACTIVE_B: decode_mode = LPSC_MODE_ACTIVE;
            default: decode_mode = LPSC_MODE_RESERVED;
        endcase
    endfunction

    // apply the standby exit copy, codes below off leave state alone
    function automatic logic [7:0] exit_copy(input logic [7:0] ctl);
        logic [7:0] r;
        r = ctl;
        if (ctl[EXIT_MSB]) begin // codes 4..7 have the top bit set
            r[STATE_MSB:STATE_LSB] = ctl[EXIT_MSB:EXIT_LSB];
        end
        exit_copy = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic exit_rise;
        exit_rise = 1'b0;
        state_next = state_reg;
        // pin synchroniser, stage 0 read only by stage 1
        state_next.exit_sync = {state_reg.exit_sync[1:0], standby_exit_pin_i};
        exit_rise = state_reg.exit_sync[1] & ~state_reg.exit_sync[2];
        state_next.oc_s1 = over_current_i;
        state_next.oc_s2 = state_reg.oc_s1;
        state_next.uv_s1 = under_voltage_i;
        state_next.uv_s2 = state_reg.uv_s1;
        // monitors follow the comparators per regulator
        state_next.oc_flag = state_reg.oc_s2;
        state_next.uv_flag = state_reg.uv_s2;
        // writes touch only the addressed register, reserved bits dropped
        if (wr_en_i && addr_i == LDO_ONE_CONTROL_ADDR) begin
            state_next.ctl_one = wr_data_i & WRITABLE_MASK;
        end
        if (wr_en_i && addr_i == LDO_TWO_CONTROL_ADDR) begin
            state_next.ctl_two = wr_data_i & WRITABLE_MASK;
        end
        // exit edge wins over a same-cycle write; relies on host setup
        if (exit_rise) begin
            state_next.ctl_one = exit_copy(state_reg.ctl_one);
            state_next.ctl_two = exit_copy(state_reg.ctl_two);
        end
        // mode only from the programmed field, never from load
        state_next.mode_one =
            decode_mode(state_reg.ctl_one[STATE_MSB:STATE_LSB]);
        state_next.mode_two =
            decode_mode(state_reg.ctl_two[STATE_MSB:STATE_LSB]);
        // reserved codes are treated as off for discharge, safer default
        state_next.discharge[0] = (state_next.mode_one == LPSC_MODE_OFF) ||
            (state_next.mode_one == LPSC_MODE_RESERVED);
        state_next.discharge[1] = (state_next.mode_two == LPSC_MODE_OFF) ||
            (state_next.mode_two == LPSC_MODE_RESERVED);
        // read mux, unmapped addresses read zero
        case (addr_i)
            LDO_ONE_CONTROL_ADDR: state_next.rd_data = state_reg.ctl_one;
            LDO_TWO_CONTROL_ADDR: state_next.rd_data = state_reg.ctl_two;
            default: state_next.rd_data = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= '0;
            state_reg.ctl_one <= LDO_ONE_CONTROL_RESET;
            state_reg.ctl_two <= LDO_TWO_CONTROL_RESET;
            state_reg.mode_one <= LPSC_MODE_OFF;
            state_reg.mode_two <= LPSC_MODE_OFF;
            state_reg.discharge <= 2'h3;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data_o = state_reg.rd_data;
    assign ldo_one_mode_o = state_reg.mode_one;
    assign ldo_two_mode_o = state_reg.mode_two;
    assign discharge_o = state_reg.discharge;
    assign over_current_o = state_reg.oc_flag;
    assign under_voltage_o = state_reg.uv_flag;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_decode;
        @(posedge clk_i) disable iff (reset_i)
        state_reg.ctl_one[STATE_MSB:STATE_LSB] == CODE_LOW_POWER
            |=> ldo_one_mode_o == LPSC_MODE_LOW_POWER;
    endproperty
    a_decode: assert property (p_decode)
        else $error("low power code not decoded");

    property p_exit;
        @(posedge clk_i) disable iff (reset_i)
        $rose(state_reg.exit_sync[1]) && state_reg.ctl_two[EXIT_MSB]
            |=> state_reg.ctl_two[STATE_MSB:STATE_LSB] ==
                $past(state_reg.ctl_two[EXIT_MSB:EXIT_LSB]);
    endproperty
    a_exit: assert property (p_exit)
        else $error("exit field not copied");

    property p_nocopy;
        @(posedge clk_i) disable iff (reset_i)
        $rose(state_reg.exit_sync[1]) && !state_reg.ctl_one[EXIT_MSB] &&
            !wr_en_i |=> $stable(state_reg.ctl_one);
    endproperty
    a_nocopy: assert property (p_nocopy)
        else $error("reserved exit code changed state");

    property p_rst_one;
        @(posedge clk_i) reset_i |=> state_reg.ctl_one == LDO_ONE_CONTROL_RESET;
    endproperty
    a_rst_one: assert property (p_rst_one)
        else $error("ldo one reset value wrong");

    property p_rst_two;
        @(posedge clk_i) reset_i |=> state_reg.ctl_two == LDO_TWO_CONTROL_RESET;
    endproperty
    a_rst_two: assert property (p_rst_two)
        else $error("ldo two reset value wrong");

    property p_indep;
        @(posedge clk_i) disable iff (reset_i)
        wr_en_i && addr_i == LDO_ONE_CONTROL_ADDR &&
            !$rose(state_reg.exit_sync[1]) |=> $stable(state_reg.ctl_two);
    endproperty
    a_indep: assert property (p_indep)
        else $error("write to ldo one disturbed ldo two");

    property p_discharge;
        @(posedge clk_i) disable iff (reset_i)
        ldo_two_mode_o == LPSC_MODE_ACTIVE |-> !discharge_o[1];
    endproperty
    a_discharge: assert property (p_discharge)
        else $error("discharge on while active");

    property p_monitor;
        @(posedge clk_i) disable iff (reset_i)
        over_current_i[0] ##1 over_current_i[0] ##1 over_current_i[0]
            |=> over_current_o[0];
    endproperty
    a_monitor: assert property (p_monitor)
        else $error("over-current not flagged");

    property p_reserved;
        @(posedge clk_i) disable iff (reset_i)
        rd_data_o[7:6] == 2'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits read nonzero");

    // ties discharge to the register field, not to the decoded mode
    property p_off_discharge;
        @(posedge clk_i) disable iff (reset_i)
        state_reg.ctl_one[STATE_MSB:STATE_LSB] == CODE_OFF
            |=> discharge_o[0];
    endproperty
    a_off_discharge: assert property (p_off_discharge)
        else $error("ldo one off without discharge");

    // low power on ldo one only ever follows the programmed code
    property p_lowpwr_only;
        @(posedge clk_i) disable iff (reset_i)
        ldo_one_mode_o == LPSC_MODE_LOW_POWER
            |-> $past(state_reg.ctl_one[STATE_MSB:STATE_LSB]) ==
                CODE_LOW_POWER;
    endproperty
    a_lowpwr_only: assert property (p_lowpwr_only)
        else $error("ldo one entered low power unprogrammed");

    c_exit: cover property (@(posedge clk_i) disable iff (reset_i)
        $rose(state_reg.exit_sync[1]) && state_reg.ctl_two[EXIT_MSB]);
    c_write: cover property (@(posedge clk_i) disable iff (reset_i)
        wr_en_i && addr_i == LDO_TWO_CONTROL_ADDR);
    c_lowpwr: cover property (@(posedge clk_i) disable iff (reset_i)
        ldo_one_mode_o == LPSC_MODE_LOW_POWER);
    // write and exit edge in one cycle, the copy must win
    c_collide: cover property (@(posedge clk_i) disable iff (reset_i)
        $rose(state_reg.exit_sync[1]) && wr_en_i);
endmodule // lpsc_top
`default_nettype wire

//--- tb/lpsc_host_model.sv
// host model that programs the two ldo control registers
`timescale 1ns/1ps
`default_nettype none
module lpsc_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rd_data_i,
    output logic wr_en_o,
    output logic [7:0] addr_o,
    output logic [7:0] wr_data_o
);
    // quiet bus from time zero
    initial begin
        wr_en_o = 1'b0;
        addr_o = 8'h00;
        wr_data_o = 8'h00;
    end
    // one-cycle strobe launched on the falling edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_en_o = 1'b1;
        addr_o = a;
        wr_data_o = d;
        @(negedge clk_i);
        wr_en_o = 1'b0;
        wr_data_o = ~d; // released data scrambled, never left stale
    endtask
    // read data is registered, so it is taken one edge later
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        @(negedge clk_i);
        d = rd_data_i;
    endtask
endmodule // lpsc_host_model
`default_nettype wire

//--- tb/lpsc_top_tb.sv
// self-checking bench for the ldo pair register bank
`timescale 1ns/1ps
`default_nettype none
module lpsc_top_tb;
    import lpsc_pkg::*;
    typedef struct packed {
        logic [7:0] a, d, rd;
        logic [1:0] m1, m2, dis;
    } lpsc_row_t;
    logic clk_i = 1'b0, reset_i = 1'b1, pin = 1'b0, wr_en;
    logic [1:0] oc_in = 2'b00, uv_in = 2'b00, m1, m2, dis, oc, uv;
    logic [7:0] addr, wdata, rd, v;
    int miscompares = 0, n_checks = 0;
    // ordinary writes: address, data, readback, modes, discharge
    lpsc_row_t rows [0:6] = '{
        '{8'h3F, 8'hFD, 8'h3D, 2'b10, 2'b01, 2'b10},
        '{8'h40, 8'h36, 8'h36, 2'b10, 2'b11, 2'b00},
        '{8'h40, 8'hC7, 8'h07, 2'b10, 2'b11, 2'b00},
        '{8'h3F, 8'h24, 8'h24, 2'b01, 2'b11, 2'b01},
        '{8'h3F, 8'h03, 8'h03, 2'b00, 2'b11, 2'b01},
        '{8'h41, 8'hFF, 8'h00, 2'b00, 2'b11, 2'b01},
        '{8'h40, 8'h2D, 8'h2D, 2'b00, 2'b10, 2'b01}};
    initial forever #10 clk_i = ~clk_i;
    lpsc_top DUT (.clk_i(clk_i), .reset_i(reset_i), .wr_en_i(wr_en),
        .addr_i(addr), .wr_data_i(wdata), .rd_data_o(rd),
        .standby_exit_pin_i(pin), .over_current_i(oc_in),
        .under_voltage_i(uv_in), .ldo_one_mode_o(m1), .ldo_two_mode_o(m2),
        .discharge_o(dis), .over_current_o(oc), .under_voltage_o(uv));
    lpsc_host_model host (.clk_i(clk_i), .rd_data_i(rd), .wr_en_o(wr_en),
        .addr_o(addr), .wr_data_o(wdata));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // mode pair and discharge compared in one go
    task automatic outs(input logic [1:0] a, b, d);
        check({2'b00, m1, m2, dis}, {2'b00, a, b, d});
    endtask
    // a hang is cut short long after the sequence should end
    initial begin
        #200000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (8) @(negedge clk_i);
        reset_i = 1'b0;
        host.read_reg(8'h3F, v);
        check(v, 8'h24);
        host.read_reg(8'h40, v);
        check(v, 8'h3C);
        outs(2'b01, 2'b01, 2'b11);
        // table of ordinary writes, reserved bits and unmapped place
        foreach (rows[i]) begin
            host.write_reg(rows[i].a, rows[i].d);
            host.read_reg(rows[i].a, v);
            check(v, rows[i].rd);
            outs(rows[i].m1, rows[i].m2, rows[i].dis);
        end
        // standby exit: valid code copied, low code left alone
        host.write_reg(8'h3F, 8'h2E);
        host.write_reg(8'h40, 8'h1F);
        pin = 1'b1;
        repeat (6) @(negedge clk_i);
        host.read_reg(8'h3F, v);
        check(v, 8'h2D);
        host.read_reg(8'h40, v);
        check(v, 8'h1F);
        outs(2'b10, 2'b11, 2'b00);
        pin = 1'b0;
        host.write_reg(8'h3F, 8'h34);
        repeat (6) @(negedge clk_i);
        pin = 1'b1;
        // a write landing on the exit edge loses to the copy
        @(negedge clk_i);
        host.write_reg(8'h40, 8'h2C);
        repeat (6) @(negedge clk_i);
        host.read_reg(8'h3F, v);
        check(v, 8'h36);
        host.read_reg(8'h40, v);
        check(v, 8'h1F);
        outs(2'b11, 2'b11, 2'b00);
        // monitor flags per regulator, both ways round
        oc_in = 2'b01;
        uv_in = 2'b10;
        repeat (5) @(negedge clk_i);
        check({4'h0, oc, uv}, 8'h06);
        oc_in = 2'b10;
        uv_in = 2'b01;
        repeat (5) @(negedge clk_i);
        check({4'h0, oc, uv}, 8'h09);
        // second reset in mid-run restores defaults
        // pin idle first, so no exit edge follows the release
        pin = 1'b0;
        reset_i = 1'b1;
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
        host.read_reg(8'h40, v);
        check(v, 8'h3C);
        host.read_reg(8'h3F, v);
        check(v, 8'h24);
        outs(2'b01, 2'b01, 2'b11);
        summarize();
    end
endmodule // lpsc_top_tb
`default_nettype wire
